// File: verilog/sen_regs.vh
`ifndef SEN_REGS_VH
`define SEN_REGS_VH
// register byte offsets
`define SEN_OFF_RIS 8'h00
`define SEN_OFF_IMC 8'h04
`define SEN_OFF_MIS 8'h08
`define SEN_OFF_ICLR 8'h0c
`define SEN_OFF_OSC 8'h10
`define SEN_OFF_NMI 8'h14
`define SEN_OFF_LDO_SLP 8'h18
`define SEN_OFF_LDO_DSLP 8'h1c
`define SEN_OFF_STATE 8'h20
// event bits
`define SEN_EV_BROWNOUT_ZERO 0
`define SEN_EV_ANALOG_GOOD 1
`define SEN_EV_OSC_POWERUP 2
`define SEN_EV_USB_PLL_LOCK 3
`define SEN_EV_SYS_PLL_LOCK 4
`define SEN_EV_OSC_FAIL 5
`define SEN_EV_BROWNOUT 6
`define SEN_EV_BROWNOUT_ONE 7
`define SEN_EV_LDO_ILIMIT 8
`define SEN_EV_INT_OSC_FAIL 9
`define SEN_EV_LDO_DROOP 10
`define SEN_EV_PLL_FAIL 11
`define SEN_EV_W 12
// oscillator control bits
`define SEN_OSC_CHECK 0
`define SEN_OSC_IRQ_SEL 1
`define SEN_OSC_NO_XTAL 2
`define SEN_OSC_PWR_OFF 3
`define SEN_OSC_RANGE_HIGH 4
`define SEN_OSC_SE_SRC 5
`define SEN_OSC_W 6
// non-maskable bits
`define SEN_NMI_OSC_MISSING 0
`define SEN_NMI_TAMPER 1
`define SEN_NMI_WDOG_ZERO 2
`define SEN_NMI_WDOG_ONE 3
`define SEN_NMI_POWER 4
`define SEN_NMI_EXTERNAL 5
`define SEN_NMI_W 6
// reset values
`define SEN_RST_MASK 12'h000
`define SEN_RST_OSC 6'h00
`define SEN_RST_LDO 3'h6
`define SEN_LDO_MAX 3'h6
// oscillator checker
`define SEN_OSC_TIMEOUT_NS 1000
`define SEN_CLK_NS 50
`define SEN_OSC_TIMEOUT_CYC (`SEN_OSC_TIMEOUT_NS / `SEN_CLK_NS)
`endif

// File: verilog/sen_osc_check.v
`timescale 1ns/1ps
`include "sen_regs.vh"
module sen_osc_check (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire enable,
   input wire osc_toggle,
   output reg fail
);
   // osc_toggle is taken as already synchronised to clk_sys
   reg last;
   reg [7:0] count;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         last <= 1'b0;
         count <= 8'h00;
         fail <= 1'b0;
      end else if (clk_en) begin
         last <= osc_toggle;
         fail <= 1'b0;
         if (!enable || last != osc_toggle) begin
            count <= 8'h00;
         end else if (count == `SEN_OSC_TIMEOUT_CYC - 1) begin
            // one pulse, then restart so a dead clock repeats the alarm
            fail <= 1'b1;
            count <= 8'h00;
         end else begin
            count <= count + 8'h01;
         end
      end
   end
endmodule

// File: verilog/sen_flagset.v
`timescale 1ns/1ps
module sen_flagset #(
   parameter W = 8
) (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire [W-1:0] set,
   input wire [W-1:0] clr,
   output reg [W-1:0] flags
);
   // set wins over a clear in the same cycle so no event is lost
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flags <= {W{1'b0}};
      end else if (clk_en) begin
         flags <= (flags & ~clr) | set;
      end
   end
endmodule

// File: verilog/sen_sysctl.v
// What this block does
// - raise events for pll lock, ldo limit, osc failures, droops, pll fail
// - raw status view and masked status view are both readable
// - status carries brownout, supply, osc, pll and fail flags
// - osc checker runs only while check enable is set
// - osc failure interrupts if selected, else resets the processor
// - no crystal setting and power off setting are held and driven
// - frequency range bit selects below or above 10 MHz
// - single ended source bit; clear means crystal
// - non-maskable status with six flags
// - writing a mask clears exactly those non-maskable flags
// - deep-sleep regulator selection, seven steps, applied in deep-sleep
// - sleep regulator selection, seven steps, applied in sleep
// - per-source enable mask gates events from the interrupt
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "sen_regs.vh"
module sen_sysctl (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire [`SEN_EV_W-1:0] event_in,
   input wire osc_toggle,
   input wire [`SEN_NMI_W-1:0] nmi_in,
   input wire sleep_mode,
   input wire deep_sleep_mode,
   output reg irq,
   output reg nmi,
   output reg osc_fail_reset,
   output reg osc_check_enable,
   output reg no_crystal_setting,
   output reg osc_power_off,
   output reg osc_range_high,
   output reg single_ended_source,
   output reg [2:0] ldo_voltage
);
   reg [`SEN_EV_W-1:0] mask;
   reg [`SEN_OSC_W-1:0] osc_ctl;
   reg [2:0] ldo_sleep;
   reg [2:0] ldo_deep;
   wire [`SEN_EV_W-1:0] raw;
   wire [`SEN_NMI_W-1:0] nmi_flags;
   wire osc_fail;
   reg [`SEN_EV_W-1:0] ev_set;
   reg [`SEN_EV_W-1:0] ev_clr;
   reg [`SEN_NMI_W-1:0] nmi_set;
   reg [`SEN_NMI_W-1:0] nmi_clr;
   reg [31:0] next_rdata;
   reg [2:0] next_ldo;

   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // out of range codes are clamped to the top step
   function [2:0] ldo_clamp;
      input [2:0] v;
      begin
         ldo_clamp = (v > `SEN_LDO_MAX) ? `SEN_LDO_MAX : v;
      end
   endfunction

   sen_osc_check u_check (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .enable(osc_ctl[`SEN_OSC_CHECK]),
      .osc_toggle(osc_toggle),
      .fail(osc_fail)
   );

   always @* begin
      ev_set = event_in;
      nmi_set = nmi_in;
      // checker failure lands in the raw event status only when interrupt is chosen; the non-maskable status always gets it
      if (osc_fail && osc_ctl[`SEN_OSC_IRQ_SEL]) begin
         ev_set[`SEN_EV_OSC_FAIL] = 1'b1;
      end
      if (osc_fail) begin
         nmi_set[`SEN_NMI_OSC_MISSING] = 1'b1;
      end
      ev_clr = {`SEN_EV_W{1'b0}};
      nmi_clr = {`SEN_NMI_W{1'b0}};
      if (wr && hit(addr, `SEN_OFF_ICLR)) begin
         ev_clr = wdata[`SEN_EV_W-1:0];
      end
      if (wr && hit(addr, `SEN_OFF_RIS)) begin
         ev_clr = wdata[`SEN_EV_W-1:0];
      end
      if (wr && hit(addr, `SEN_OFF_NMI)) begin
         nmi_clr = wdata[`SEN_NMI_W-1:0];
      end
   end

   sen_flagset #(.W(`SEN_EV_W)) u_ev (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .set(ev_set),
      .clr(ev_clr),
      .flags(raw)
   );

   sen_flagset #(.W(`SEN_NMI_W)) u_nmi (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .set(nmi_set),
      .clr(nmi_clr),
      .flags(nmi_flags)
   );

   always @* begin
      next_rdata = 32'h00000000;
      case (addr)
         `SEN_OFF_RIS: next_rdata[`SEN_EV_W-1:0] = raw;
         `SEN_OFF_IMC: next_rdata[`SEN_EV_W-1:0] = mask;
         `SEN_OFF_MIS: next_rdata[`SEN_EV_W-1:0] = raw & mask;
         `SEN_OFF_OSC: next_rdata[`SEN_OSC_W-1:0] = osc_ctl;
         `SEN_OFF_NMI: next_rdata[`SEN_NMI_W-1:0] = nmi_flags;
         `SEN_OFF_LDO_SLP: next_rdata[2:0] = ldo_sleep;
         `SEN_OFF_LDO_DSLP: next_rdata[2:0] = ldo_deep;
         `SEN_OFF_STATE: next_rdata[2:0] = ldo_voltage;
         default: next_rdata = 32'h00000000;
      endcase
      if (deep_sleep_mode) begin
         next_ldo = ldo_deep;
      end else if (sleep_mode) begin
         next_ldo = ldo_sleep;
      end else begin
         // run mode keeps the regulator at the top step
         next_ldo = `SEN_LDO_MAX;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mask <= `SEN_RST_MASK;
         osc_ctl <= `SEN_RST_OSC;
         ldo_sleep <= `SEN_RST_LDO;
         ldo_deep <= `SEN_RST_LDO;
         rdata <= 32'h00000000;
         irq <= 1'b0;
         nmi <= 1'b0;
         osc_fail_reset <= 1'b0;
         osc_check_enable <= 1'b0;
         no_crystal_setting <= 1'b0;
         osc_power_off <= 1'b0;
         osc_range_high <= 1'b0;
         single_ended_source <= 1'b0;
         ldo_voltage <= `SEN_RST_LDO;
      end else if (clk_en) begin
         if (wr && hit(addr, `SEN_OFF_IMC)) begin
            mask <= wdata[`SEN_EV_W-1:0];
         end
         if (wr && hit(addr, `SEN_OFF_OSC)) begin
            osc_ctl <= wdata[`SEN_OSC_W-1:0];
         end
         if (wr && hit(addr, `SEN_OFF_LDO_SLP)) begin
            ldo_sleep <= ldo_clamp(wdata[2:0]);
         end
         if (wr && hit(addr, `SEN_OFF_LDO_DSLP)) begin
            ldo_deep <= ldo_clamp(wdata[2:0]);
         end
         rdata <= rd ? next_rdata : 32'h00000000;
         irq <= |(raw & mask);
         nmi <= |nmi_flags;
         osc_fail_reset <= osc_fail && !osc_ctl[`SEN_OSC_IRQ_SEL];
         osc_check_enable <= osc_ctl[`SEN_OSC_CHECK];
         no_crystal_setting <= osc_ctl[`SEN_OSC_NO_XTAL];
         osc_power_off <= osc_ctl[`SEN_OSC_PWR_OFF];
         osc_range_high <= osc_ctl[`SEN_OSC_RANGE_HIGH];
         single_ended_source <= osc_ctl[`SEN_OSC_SE_SRC];
         ldo_voltage <= next_ldo;
      end
   end
endmodule

// File: test/sen_sysctl_asserts.sv
`timescale 1ns/1ps
module sen_sysctl_chk (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire [5:0] nmi_in,
   input wire sleep_mode,
   input wire deep_sleep_mode,
   input wire irq,
   input wire nmi,
   input wire osc_fail_reset,
   input wire osc_range_high,
   input wire [2:0] ldo_voltage
);
   default clocking @(posedge clk_sys); endclocking
   // a frozen block holds every output, so timing checks pause with it
   default disable iff (!rst_b || !clk_en);
   chk_rd_idle: assert property (!rd |=> rdata == 32'h0)
      else $error("read data outside read slot");
   chk_rd_unmapped: assert property (rd && addr >= 8'h24 |=> !rdata)
      else $error("unmapped read not zero");
   chk_raw_width: assert property (rd && addr == 8'h00 |=>
      rdata[31:12] == 20'h0) else $error("raw reserved bits set");
   chk_mask_off: assert property (wr && addr == 8'h04 &&
      wdata[11:0] == 12'h0 |=> ##2 !irq [*2]) else $error("masked irq");
   chk_nmi_raise: assert property (nmi_in != 6'h0 |=> ##1 nmi)
      else $error("nmi not raised");
   chk_run_ldo: assert property (!sleep_mode && !deep_sleep_mode |=>
      ldo_voltage == 3'h6) else $error("run ldo not 6");
   chk_ldo_steps: assert property (ldo_voltage != 3'h7)
      else $error("ldo code out of range");
   // a second write right behind would legally overtake the first
   chk_osc_copy: assert property (wr && addr == 8'h10 ##1
      !(wr && addr == 8'h10) |=> ##1 osc_range_high == $past(wdata[4], 3))
      else $error("range output wrong");
   cover property (irq);
   cover property (osc_fail_reset);
   cover property (ldo_voltage == 3'h0);
endmodule
bind sen_sysctl sen_sysctl_chk u_chk (.clk_sys, .rst_b, .clk_en, .addr, .wdata,
   .wr, .rd, .rdata, .nmi_in, .sleep_mode, .deep_sleep_mode, .irq, .nmi,
   .osc_fail_reset, .osc_range_high, .ldo_voltage);

// File: test/sen_sysctl_bench.sv
`timescale 1ns/1ps
module sen_sysctl_bench;
   reg clk_sys = 0, rst_b = 0, wr = 0, rd = 0, osc_run = 1, osc_toggle = 0;
   reg sleep_mode = 0, deep_sleep_mode = 0, clk_en = 1;
   reg [7:0] addr = 0;
   reg [31:0] wdata = 0;
   reg [11:0] event_in = 0;
   reg [5:0] nmi_in = 0;
   wire [31:0] rdata;
   wire irq, nmi, osc_fail_reset, chk_en, no_xtal, pwr_off, rng, se;
   wire [2:0] ldo_voltage;
   integer failures = 0, comparisons = 0, i, seen = 0;
   sen_sysctl DUT (.clk_sys, .rst_b, .clk_en, .addr, .wdata, .wr,
      .rd, .rdata, .event_in, .osc_toggle, .nmi_in, .sleep_mode,
      .deep_sleep_mode, .irq, .nmi, .osc_fail_reset,
      .osc_check_enable(chk_en), .no_crystal_setting(no_xtal),
      .osc_power_off(pwr_off), .osc_range_high(rng),
      .single_ended_source(se), .ldo_voltage);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (osc_run) osc_toggle <= ~osc_toggle;
   always @(posedge clk_sys) if (osc_fail_reset) seen <= seen + 1;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t %h %h", $time, got, exp);
         end
      end
   endtask
   task waitc(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_sys);
         wr <= 1;
         addr <= a;
         wdata <= d;
         @(posedge clk_sys);
         wr <= 0;
      end
   endtask
   task rd_chk(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk_sys);
         rd <= 1;
         addr <= a;
         @(posedge clk_sys);
         rd <= 0;
         #1;
         chk(rdata, exp);
      end
   endtask
   task pulse(input [11:0] e, input [5:0] n);
      begin
         @(posedge clk_sys);
         event_in <= e;
         nmi_in <= n;
         @(posedge clk_sys);
         event_in <= 0;
         nmi_in <= 0;
         waitc(3);
      end
   endtask
   task t_regs;
      begin
         rd_chk(8'h04, 0);
         rd_chk(8'h10, 0);
         rd_chk(8'h1c, 6);
         rd_chk(8'h24, 0);
         wr_reg(8'h18, 7);
         rd_chk(8'h18, 6);
         wr_reg(8'h18, 0);
         wr_reg(8'h1c, 4);
         sleep_mode <= 1;
         waitc(2);
         chk(ldo_voltage, 0);
         @(posedge clk_sys);
         deep_sleep_mode <= 1;
         waitc(2);
         chk(ldo_voltage, 4);
         @(posedge clk_sys);
         sleep_mode <= 0;
         deep_sleep_mode <= 0;
         waitc(2);
         chk(ldo_voltage, 6);
      end
   endtask
   task t_freeze;
      begin
         @(posedge clk_sys);
         clk_en <= 0;
         pulse(12'h010, 6'h01);
         @(posedge clk_sys);
         clk_en <= 1;
         rd_chk(8'h00, 0);
         rd_chk(8'h14, 0);
         chk(irq, 0);
      end
   endtask
   task t_irq;
      begin
         wr_reg(8'h04, 32'hfff);
         for (i = 0; i < 12; i = i + 1) begin
            pulse(12'h1 << i, 0);
            chk(irq, 1);
            rd_chk(8'h00, 32'h1 << i);
            rd_chk(8'h08, 32'h1 << i);
            chk(irq, 1);
            wr_reg(8'h0c, 32'h1 << i);
            rd_chk(8'h00, 0);
         end
         wr_reg(8'h04, 32'h010);
         pulse(12'h040, 0);
         rd_chk(8'h00, 32'h40);
         rd_chk(8'h08, 0);
         chk(irq, 0);
         wr_reg(8'h0c, 32'h40);
         pulse(12'h010, 0);
         chk(irq, 1);
         wr_reg(8'h04, 32'h0);
         waitc(3);
         chk(irq, 0);
         wr_reg(8'h0c, 32'h10);
      end
   endtask
   task t_nmi;
      begin
         pulse(0, 6'h3f);
         chk(nmi, 1);
         rd_chk(8'h14, 32'h3f);
         wr_reg(8'h14, 32'h05);
         rd_chk(8'h14, 32'h3a);
         wr_reg(8'h14, 32'h3a);
         waitc(2);
         chk(nmi, 0);
      end
   endtask
   task t_osc;
      begin
         wr_reg(8'h10, 32'h02);
         osc_run <= 0;
         waitc(30);
         rd_chk(8'h00, 0);
         wr_reg(8'h10, 32'h13);
         waitc(30);
         chk({se, rng, pwr_off, no_xtal, chk_en}, 32'h09);
         rd_chk(8'h00, 32'h20);
         chk(seen, 0);
         wr_reg(8'h10, 32'h2d);
         waitc(30);
         chk(seen != 0, 1);
         chk({se, rng, pwr_off, no_xtal, chk_en}, 32'h17);
         rd_chk(8'h14, 32'h01);
      end
   endtask
   task tally_and_finish;
      begin
         if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1;
      t_regs;
      t_irq;
      t_nmi;
      t_freeze;
      t_osc;
      tally_and_finish;
   end
   initial begin
      #400000;
      failures = failures + 1;
      tally_and_finish;
   end
endmodule
